//--- bench/gcs_nvm_model.sv
// storage model standing behind the block's non-volatile port
`default_nettype none
module gcs_nvm_model (
    input  wire logic       clock,
    input  wire logic       nvm_rd,
    input  wire logic       nvm_wr,
    input  wire logic [7:0] nvm_class,
    input  wire logic [7:0] nvm_page,
    input  wire logic [4:0] nvm_index,
    input  wire logic [7:0] nvm_wdata,
    output var  logic [7:0] nvm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [int];
    int         key;
    always @(posedge clock) begin
        key = {nvm_class, nvm_page, 3'h0, nvm_index};
        if (nvm_wr)
            mem[key] = nvm_wdata; // only bytes handed over change
        // the line toggles between reads so a stale byte never passes
        if (nvm_rd)
            nvm_rdata <= mem.exists(key) ? mem[key]
                         : nvm_class ^ {nvm_page[2:0], nvm_index};
        else
            nvm_rdata <= ~nvm_rdata;
    end
endmodule
`default_nettype wire

//--- bench/gcs_window_asserts.sv
// concurrent checks on the command port and the non-volatile port
`default_nettype none
module gcs_chk (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic [7:0] cmd_addr,
    input wire logic       cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic       cmd_rd,
    input wire logic [7:0] cmd_rdata,
    input wire logic       busy,
    input wire logic       unlocked_state,
    input wire logic       nvm_rd,
    input wire logic       nvm_wr,
    input wire logic [4:0] nvm_index,
    input wire logic       commit_ok,
    input wire logic       commit_bad
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic wr_ok;
    assign wr_ok = cmd_wr && !busy;
    ////////////////////////////////////////////////////////////////////////
    property p_acc_load;
        wr_ok && unlocked_state && cmd_addr == 8'h61 && cmd_wdata == 8'h00
        |=> busy ##1 nvm_rd && nvm_index == 5'h00;
    endproperty
    a_acc_load: assert property (p_acc_load)
        else $error("no block load after access select");
    property p_rd_step;
        nvm_rd && nvm_index != 5'h1f
        |=> nvm_rd && nvm_index == $past(nvm_index) + 5'h01;
    endproperty
    a_rd_step: assert property (p_rd_step)
        else $error("block load skipped a byte");
    property p_rd_last; nvm_rd && nvm_index == 5'h1f |=> !nvm_rd; endproperty
    a_rd_last: assert property (p_rd_last)
        else $error("block load ran past 32 bytes");
    property p_class_lock;
        wr_ok && !unlocked_state && cmd_addr == 8'h3e |=> !busy [*2];
    endproperty
    a_class_lock: assert property (p_class_lock)
        else $error("class write acted on while locked");
    property p_rd_lock;
        cmd_rd && !unlocked_state && cmd_addr == 8'h3e |=> cmd_rdata == 8'h00;
    endproperty
    a_rd_lock: assert property (p_rd_lock)
        else $error("class readable while locked");
    property p_bad_nowr; commit_bad |-> !busy && !nvm_wr; endproperty
    a_bad_nowr: assert property (p_bad_nowr)
        else $error("rejected block still written");
    property p_bad_why;
        commit_bad |-> $past(wr_ok && cmd_addr == 8'h60);
    endproperty
    a_bad_why: assert property (p_bad_why)
        else $error("reject without a block sum write");
    property p_ok_busy; commit_ok |-> $past(busy); endproperty
    a_ok_busy: assert property (p_ok_busy)
        else $error("commit done without a transfer");
    c_ok: cover property (commit_ok);
    c_bad: cover property (commit_bad);
    c_load: cover property (nvm_rd && nvm_index == 5'h1f);
endmodule
`default_nettype wire

//--- bench/test_gauge_command_space_flash_window.sv
// self-checking bench for the gauge command space and block window
`default_nettype none
module test_gauge_command_space_flash_window;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MFG = 8'h5c; // arbitrary manufacturer class
    localparam logic [7:0] WA [9] = '{8'h3a, 8'h3c, 8'h64, 8'h66, 8'h68,
                                      8'h6a, 8'h6e, 8'h70, 8'h74};
    logic        clock, nrst, cmd_wr, cmd_rd, busy, unlocked_state, bad, ok;
    logic        discharging, resistance_update_disable, cap_updated;
    logic        gauging_enabled, sec_tick, voltage_ok_flag;
    logic        nvm_rd, nvm_wr, commit_ok, commit_bad;
    logic [1:0]  temp_range, capacity_learn_state, gauge_state;
    logic [4:0]  nvm_index;
    logic [7:0]  cmd_addr, cmd_wdata, cmd_rdata, grid_point_in, cls, pg;
    logic [7:0]  nvm_class, nvm_page, nvm_wdata, nvm_rdata, got;
    logic [7:0]  win [32];
    logic [15:0] w [11];
    logic [15:0] v, cv, cc;
    int          error_cnt, samples_checked, idx;
    gcs_window #(.MFG_CLASS(MFG)) i_dut (
        .clock(clock), .nrst(nrst), .cmd_addr(cmd_addr), .cmd_wr(cmd_wr),
        .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
        .busy(busy), .unlocked_state(unlocked_state),
        .temp_range(temp_range), .charge_voltage_in(w[9]),
        .charge_current_in(w[10]), .pack_config_in(w[0]),
        .nominal_capacity_in(w[1]), .discharging(discharging),
        .resistance_update_disable(resistance_update_disable),
        .grid_point_in(grid_point_in), .cap_updated(cap_updated),
        .gauging_enabled(gauging_enabled),
        .capacity_learn_state(capacity_learn_state), .dod_eoc_in(w[2]),
        .init_cap_in(w[3]), .true_rc_in(w[4]), .true_fcc_in(w[5]),
        .gauge_state(gauge_state), .sec_tick(sec_tick),
        .qmax_passed_in(w[6]), .dod_ocv_in(w[7]),
        .voltage_ok_flag(voltage_ok_flag), .saved_dod_in(v),
        .qmax_time_in(w[8]), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
        .nvm_class(nvm_class), .nvm_page(nvm_page), .nvm_index(nvm_index),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .commit_ok(commit_ok), .commit_bad(commit_bad));
    gcs_nvm_model i_nvm (
        .clock(clock), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
        .nvm_class(nvm_class), .nvm_page(nvm_page), .nvm_index(nvm_index),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_wr = 1'b1;
        step;
        cmd_wr = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        step;
        cmd_addr = a;
        cmd_rd = 1'b1;
        step;
        cmd_rd = 1'b0;
        chk(cmd_rdata, e);
    endtask
    task automatic rdw(input logic [7:0] a, input logic [15:0] e);
        rdchk(a, e[7:0]);
        rdchk(a + 8'h01, e[15:8]);
    endtask
    task automatic idle;
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n == 100) begin
                error_cnt++;
                $display("ERROR %0t: busy never dropped", $time);
                close_out;
            end
            step;
        end
    endtask
    // commit pulses are short, so every cycle of the transfer is looked at
    task automatic watch;
        bad = 1'b0;
        ok = 1'b0;
        repeat (45) begin
            bad |= commit_bad;
            ok |= commit_ok;
            step;
        end
    endtask
    function automatic logic [7:0] bsum;
        logic [7:0] s;
        s = 8'h00;
        foreach (win[i])
            s += win[i];
        return 8'hff - s;
    endfunction
    function automatic logic [7:0] dflt(input logic [7:0] c,
                                        input logic [7:0] p, input int i);
        return c ^ {p[2:0], i[4:0]};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {cmd_wr, cmd_rd, sec_tick, nrst, unlocked_state, discharging} = '0;
        {resistance_update_disable, cap_updated, gauging_enabled} = '0;
        {voltage_ok_flag, temp_range, capacity_learn_state} = '0;
        {gauge_state, cmd_addr, cmd_wdata, grid_point_in, v} = '0;
        error_cnt = 0;
        samples_checked = 0;
        void'($urandom(34706));
        foreach (w[i])
            w[i] = 16'($urandom) | 16'h0001;
        repeat (5) @(posedge clock);
        #1 nrst = 1'b1;
        foreach (WA[i])
            rdw(WA[i], w[i]);
        cv = w[9];
        cc = w[10];
        w[9] = ~cv;
        w[10] = ~cc;
        rdw(8'h30, cv);
        rdw(8'h32, cc);
        temp_range = 2'h2;
        rdw(8'h30, w[9]);
        rdw(8'h32, w[10]);
        wr(8'h3e, 8'h55);
        rdchk(8'h3e, 8'h00);
        rdchk(8'h7f, 8'h00);
        discharging = 1'b1;
        got = 8'($urandom);
        grid_point_in = got;
        rdchk(8'h62, got);
        resistance_update_disable = 1'b1;
        grid_point_in = ~got;
        rdchk(8'h62, got);
        for (int k = 0; k < 2; k++) begin
            {cap_updated, gauging_enabled} = 2'($urandom);
            capacity_learn_state = 2'(k);
            got = {4'h0, cap_updated, gauging_enabled, 2'(k)};
            rdchk(8'h63, got);
        end
        voltage_ok_flag = 1'b1;
        v = 16'($urandom);
        cv = v;
        rdw(8'h72, cv);
        voltage_ok_flag = 1'b0;
        v = ~cv;
        rdw(8'h72, cv);
        for (int j = 0; j < 2; j++) begin
            gauge_state = 2'(j);
            step;
            repeat (3) begin
                sec_tick = 1'b1;
                step;
                sec_tick = 1'b0;
                step;
            end
        end
        rdw(8'h6c, 16'h0003);
        unlocked_state = 1'b1;
        wr(8'h61, 8'h00);
        idle;
        for (int j = 0; j < 2; j++) begin
            cls = 8'($urandom);
            pg = 8'($urandom % 4);
            wr(8'h3e, cls);
            idle;
            wr(8'h3f, pg);
            idle;
            foreach (win[i]) begin
                win[i] = dflt(cls, pg, i);
                rdchk(8'h40 + 8'(i), win[i]);
            end
            rdchk(8'h60, bsum());
            repeat (3) begin
                idx = $urandom % (j ? 8 : 32);
                win[idx] = 8'($urandom);
                wr(8'h40 + 8'(idx), win[idx]);
            end
            wr(8'h60, bsum() + 8'h01);
            watch;
            chk(8'({bad, ok}), 8'h02);
            wr(8'h60, bsum());
            watch;
            chk(8'({bad, ok}), 8'h01);
            idle;
            wr(8'h3f, pg);
            idle;
            foreach (win[i])
                rdchk(8'h40 + 8'(i), win[i]);
        end
        wr(8'h61, 8'h01);
        idle;
        wr(8'h3f, 8'h01);
        idle;
        rdchk(8'h40, dflt(MFG, 8'h01, 0));
        wr(8'h3f, 8'h00);
        chk(8'(busy), 8'h00);
        wr(8'h40, 8'ha5);
        rdchk(8'h40, 8'ha5);
        close_out;
    end
endmodule
bind gcs_window gcs_chk i_chk (.clock(clock), .nrst(nrst),
    .cmd_addr(cmd_addr), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .busy(busy),
    .unlocked_state(unlocked_state), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
    .nvm_index(nvm_index), .commit_ok(commit_ok), .commit_bad(commit_bad));
`default_nettype wire

//--- hw/gcs_consts.vh
// command-space offsets, field positions, reset values and counts
`ifndef GCS_CONSTS_VH
`define GCS_CONSTS_VH

`define GCS_CHG_VOLT      8'h30
`define GCS_CHG_CURR      8'h32
`define GCS_PACK_CFG      8'h3a
`define GCS_NOM_CAP       8'h3c
`define GCS_CLASS_SEL     8'h3e
`define GCS_PAGE_SEL      8'h3f
`define GCS_WIN_BASE      8'h40
`define GCS_WIN_LAST      8'h5f
`define GCS_AUTH_SUM      8'h54
`define GCS_BLOCK_SUM     8'h60
`define GCS_ACCESS_SEL    8'h61
`define GCS_GRID_PT       8'h62
`define GCS_LEARN_ST      8'h63
`define GCS_DOD_EOC       8'h64
`define GCS_INIT_CAP      8'h66
`define GCS_TRUE_RC       8'h68
`define GCS_TRUE_FCC      8'h6a
`define GCS_STATE_TIME    8'h6c
`define GCS_QMAX_PASSED   8'h6e
`define GCS_DOD_OCV       8'h70
`define GCS_SAVED_DOD     8'h72
`define GCS_QMAX_TIME     8'h74

`define GCS_LS_CAP_UPD    3
`define GCS_LS_GAUGE_EN   2

`define GCS_ACC_GENERAL   8'h00
`define GCS_PAGE_AUTH     8'h00
`define GCS_SUM_BASE      8'hff
`define GCS_BLOCK_LEN     6'h20
`define GCS_RST_BYTE      8'h00
`define GCS_RST_WORD      16'h0000
`define GCS_TIME_MAX      16'hffff

`endif

//--- hw/gcs_window.v
// command space, block window and non-volatile block transfer of the gauge
//
// How it works
// R1: charge voltage word latched on temperature range change
// R2: charge current word refreshed per temperature range
// R3: nominal capacity word read-only from config
// R4: class select writable only when unlocked
// R5: general mode page select picks 32-byte block
// R6: restricted page 0 auth, 1 manufacturer data
// R7: bytes 0x40-0x53 challenge buffer and block head
// R8: byte 0x54 auth sum or block byte
// R9: bytes 0x55-0x5f rest of block image
// R10: block sum byte holds window checksum
// R11: access select 0 general, 1 restricted paging
// R12: grid point updates only discharging, not disabled
// R13: learn byte bit3 cap updated, bit2 gauging
// R14: learn byte bits 1:0 capacity learn state
// R15: saved depth taken only while voltage ok
// R16: time since last discharge/charge/rest change
// R17: unsmoothed capacities passed through directly
// R18: commit only on correct block sum write
// R19: host pages by offset/32, indexes offset mod 32
// R20: window bytes readable and writable individually
// R21: host selects general access before byte access
// R22: block access needs unlock, measurements always
// R23: sum is 255 minus wrapping byte sum
// R24: short commit leaves bytes past length untouched
// R25: wrong sum discards commit
`include "gcs_consts.vh"
`default_nettype none

module gcs_window #(
    parameter [7:0] MFG_CLASS = 8'h3a
) (
    input  wire        clock,
    input  wire        nrst,
    input  wire [7:0]  cmd_addr,
    input  wire        cmd_wr,
    input  wire [7:0]  cmd_wdata,
    input  wire        cmd_rd,
    output reg  [7:0]  cmd_rdata,
    output wire        busy,
    input  wire        unlocked_state,
    input  wire [1:0]  temp_range,
    input  wire [15:0] charge_voltage_in,
    input  wire [15:0] charge_current_in,
    input  wire [15:0] pack_config_in,
    input  wire [15:0] nominal_capacity_in,
    input  wire        discharging,
    input  wire        resistance_update_disable,
    input  wire [7:0]  grid_point_in,
    input  wire        cap_updated,
    input  wire        gauging_enabled,
    input  wire [1:0]  capacity_learn_state,
    input  wire [15:0] dod_eoc_in,
    input  wire [15:0] init_cap_in,
    input  wire [15:0] true_rc_in,
    input  wire [15:0] true_fcc_in,
    input  wire [1:0]  gauge_state,
    input  wire        sec_tick,
    input  wire [15:0] qmax_passed_in,
    input  wire [15:0] dod_ocv_in,
    input  wire        voltage_ok_flag,
    input  wire [15:0] saved_dod_in,
    input  wire [15:0] qmax_time_in,
    output reg         nvm_rd,
    output reg         nvm_wr,
    output reg  [7:0]  nvm_class,
    output reg  [7:0]  nvm_page,
    output reg  [4:0]  nvm_index,
    output reg  [7:0]  nvm_wdata,
    input  wire [7:0]  nvm_rdata,
    output reg         commit_ok,
    output reg         commit_bad
);

    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_LOAD   = 3'b010;
    localparam [2:0] ST_COMMIT = 3'b100;

    reg [2:0]  state_q;
    reg [7:0]  win_q [0:31];
    reg [7:0]  class_q;
    reg [7:0]  page_q;
    reg [7:0]  access_q;
    reg [7:0]  sum_byte_q;
    reg [5:0]  len_q;
    reg [5:0]  idx_q;
    reg        cap_q;
    reg [4:0]  cap_idx_q;
    reg [1:0]  range_q;
    reg [15:0] volt_q;
    reg [15:0] curr_q;
    reg [7:0]  grid_q;
    reg [15:0] saved_dod_q;
    reg [1:0]  gstate_q;
    reg [15:0] time_q;
    reg [7:0]  wsum;
    reg [7:0]  rd_d;
    integer    i;
    integer    k;

    // locked counts as restricted: only manufacturer pages and the
    // challenge buffer stay reachable then
    wire restricted = !unlocked_state || (access_q != `GCS_ACC_GENERAL);
    wire auth_mode  = restricted && (page_q == `GCS_PAGE_AUTH);
    wire [7:0] expect_sum = `GCS_SUM_BASE - wsum;
    wire win_hit = (cmd_addr >= `GCS_WIN_BASE) &&
                   (cmd_addr <= `GCS_WIN_LAST);
    wire [4:0] win_idx = cmd_addr[4:0];
    wire idle = state_q == ST_IDLE;

    // writes that arrive while busy are dropped; the host must poll busy
    assign busy = !idle;

    ////////////////////////////////////////////////////////////////////////
    // checksum over the whole window, wrapping byte by byte

    always @* begin
        wsum = 8'h00;
        for (i = 0; i < 32; i = i + 1) begin
            wsum = wsum + win_q[i]; // [R23]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live measurement words

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            range_q     <= 2'h0;
            volt_q      <= `GCS_RST_WORD;
            curr_q      <= `GCS_RST_WORD;
            grid_q      <= `GCS_RST_BYTE;
            saved_dod_q <= `GCS_RST_WORD;
            gstate_q    <= 2'h0;
            time_q      <= `GCS_RST_WORD;
        end else begin
            range_q <= temp_range;
            // first cycle after reset also loads, since volt_q still holds the reset word
            if (range_q != temp_range || volt_q == `GCS_RST_WORD) begin
                volt_q <= charge_voltage_in; // [R1]
                curr_q <= charge_current_in; // [R2]
            end
            if (discharging && !resistance_update_disable) begin
                grid_q <= grid_point_in; // [R12]
            end
            if (voltage_ok_flag) begin
                saved_dod_q <= saved_dod_in; // [R15]
            end
            gstate_q <= gauge_state;
            // a state change wins over a tick in the same cycle
            if (gstate_q != gauge_state) begin
                time_q <= `GCS_RST_WORD; // [R16]
            end else if (sec_tick && time_q != `GCS_TIME_MAX) begin
                time_q <= time_q + 16'h0001; // saturates rather than wraps
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; words give low byte at the even command, high byte at the odd one; paired byte registers share the even/odd slots

    function [7:0] pick;
        input [15:0] w;
        input        hi;
        begin
            pick = hi ? w[15:8] : w[7:0];
        end
    endfunction

    always @* begin
        rd_d = 8'h00;
        if (win_hit) begin
            rd_d = win_q[win_idx]; // [R20] [R7] [R8] [R9]
        end else begin
            case ({cmd_addr[7:1], 1'b0})
                `GCS_CHG_VOLT:    rd_d = pick(volt_q, cmd_addr[0]);
                `GCS_CHG_CURR:    rd_d = pick(curr_q, cmd_addr[0]);
                `GCS_PACK_CFG:    rd_d = pick(pack_config_in, cmd_addr[0]);
                `GCS_NOM_CAP:     rd_d = pick(nominal_capacity_in,
                                              cmd_addr[0]); // [R3]
                `GCS_CLASS_SEL:   rd_d = cmd_addr[0] ? page_q :
                                         (unlocked_state ? class_q : 8'h00);
                `GCS_BLOCK_SUM:   rd_d = cmd_addr[0] ?
                                         (unlocked_state ? access_q : 8'h00)
                                         : sum_byte_q; // [R10]
                `GCS_GRID_PT:     rd_d = cmd_addr[0] ?
                                         {4'h0, cap_updated, gauging_enabled,
                                          capacity_learn_state} // [R13] [R14]
                                         : grid_q;
                `GCS_DOD_EOC:     rd_d = pick(dod_eoc_in, cmd_addr[0]);
                `GCS_INIT_CAP:    rd_d = pick(init_cap_in, cmd_addr[0]);
                `GCS_TRUE_RC:     rd_d = pick(true_rc_in,
                                              cmd_addr[0]); // [R17]
                `GCS_TRUE_FCC:    rd_d = pick(true_fcc_in,
                                              cmd_addr[0]); // [R17]
                `GCS_STATE_TIME:  rd_d = pick(time_q, cmd_addr[0]);
                `GCS_QMAX_PASSED: rd_d = pick(qmax_passed_in, cmd_addr[0]);
                `GCS_DOD_OCV:     rd_d = pick(dod_ocv_in, cmd_addr[0]);
                `GCS_SAVED_DOD:   rd_d = pick(saved_dod_q, cmd_addr[0]);
                `GCS_QMAX_TIME:   rd_d = pick(qmax_time_in, cmd_addr[0]);
                default:          rd_d = 8'h00;
            endcase
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cmd_rdata <= 8'h00;
        end else if (cmd_rd) begin
            cmd_rdata <= rd_d; // [R22]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selects, window and transfer sequencer

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_IDLE;
            class_q    <= `GCS_RST_BYTE;
            page_q     <= `GCS_RST_BYTE;
            access_q   <= `GCS_RST_BYTE;
            sum_byte_q <= `GCS_RST_BYTE;
            len_q      <= 6'h00;
            idx_q      <= 6'h00;
            cap_q      <= 1'b0;
            cap_idx_q  <= 5'h00;
            nvm_rd     <= 1'b0;
            nvm_wr     <= 1'b0;
            nvm_class  <= 8'h00;
            nvm_page   <= 8'h00;
            nvm_index  <= 5'h00;
            nvm_wdata  <= 8'h00;
            commit_ok  <= 1'b0;
            commit_bad <= 1'b0;
            for (k = 0; k < 32; k = k + 1) begin
                win_q[k] <= 8'h00;
            end
        end else begin
            nvm_rd     <= 1'b0;
            nvm_wr     <= 1'b0;
            commit_ok  <= 1'b0;
            commit_bad <= 1'b0;
            // storage answers one cycle after each read strobe; the index
            // travels with the strobe so each byte lands where it was read
            cap_q     <= nvm_rd;
            cap_idx_q <= nvm_index;
            if (cap_q) begin
                win_q[cap_idx_q] <= nvm_rdata;
            end
            case (state_q)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        if (cmd_addr == `GCS_CLASS_SEL && unlocked_state) begin
                            class_q <= cmd_wdata; // [R4] [R22]
                            if (!restricted) begin
                                nvm_class <= cmd_wdata;
                                nvm_page  <= page_q;
                                idx_q     <= 6'h00;
                                len_q     <= 6'h00;
                                state_q   <= ST_LOAD;
                            end
                        end else if (cmd_addr == `GCS_PAGE_SEL) begin
                            page_q <= cmd_wdata;
                            len_q  <= 6'h00;
                            idx_q  <= 6'h00;
                            if (!restricted) begin
                                nvm_class <= class_q; // [R5]
                                nvm_page  <= cmd_wdata;
                                state_q   <= ST_LOAD;
                            end else if (cmd_wdata != `GCS_PAGE_AUTH) begin
                                nvm_class <= MFG_CLASS; // [R6]
                                nvm_page  <= cmd_wdata;
                                state_q   <= ST_LOAD;
                            end
                        end else if (cmd_addr == `GCS_ACCESS_SEL &&
                                     unlocked_state) begin
                            access_q <= cmd_wdata; // [R11]
                            if (cmd_wdata == `GCS_ACC_GENERAL) begin
                                nvm_class <= class_q; // [R21]
                                nvm_page  <= page_q;
                                idx_q     <= 6'h00;
                                len_q     <= 6'h00;
                                state_q   <= ST_LOAD;
                            end
                        end else if (win_hit) begin
                            win_q[win_idx] <= cmd_wdata; // [R20]
                            // track how far the host has written
                            if ({1'b0, win_idx} >= len_q) begin
                                len_q <= {1'b0, win_idx} + 6'h01;
                            end
                        end else if (cmd_addr == `GCS_BLOCK_SUM) begin
                            sum_byte_q <= cmd_wdata; // [R10]
                            // in auth mode the sum is challenge data only
                            if (!auth_mode) begin
                                if (cmd_wdata == expect_sum) begin
                                    idx_q   <= 6'h00; // [R18]
                                    state_q <= ST_COMMIT;
                                end else begin
                                    commit_bad <= 1'b1; // [R25]
                                end
                            end
                        end
                    end
                end
                ST_LOAD: begin
                    if (idx_q < `GCS_BLOCK_LEN) begin
                        nvm_rd    <= 1'b1;
                        nvm_index <= idx_q[4:0];
                        idx_q     <= idx_q + 6'h01;
                    end else if (!nvm_rd && !cap_q) begin
                        // last answer has landed, so the sum covers all 32
                        sum_byte_q <= expect_sum; // [R10]
                        state_q    <= ST_IDLE;
                    end
                end
                ST_COMMIT: begin
                    // only the written length goes back; bytes beyond stay
                    if (idx_q < len_q) begin
                        nvm_wr    <= 1'b1; // [R24]
                        nvm_index <= idx_q[4:0];
                        nvm_wdata <= win_q[idx_q[4:0]];
                        idx_q     <= idx_q + 6'h01;
                    end else begin
                        commit_ok <= 1'b1;
                        len_q     <= 6'h00;
                        state_q   <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire
